// ---- logic/tims_defs.vh ----
`ifndef TIMS_DEFS_VH
`define TIMS_DEFS_VH

// apb register byte offsets
`define TIMS_CTRL_OFF      12'h000
`define TIMS_CFG_OFF       12'h004
`define TIMS_POS_OFF       12'h008
`define TIMS_STAT_OFF      12'h00c
`define TIMS_CHAIN_OFF     12'h010

// ctrl field positions
`define TIMS_CTRL_MASTER   0
`define TIMS_CTRL_SYNC     1
`define TIMS_CTRL_TERM_MAN 2
`define TIMS_CTRL_TERM_WE  3
`define TIMS_CTRL_ADDR_WE  4
`define TIMS_CTRL_RAMP_EN  5

// reset values
`define TIMS_CTRL_RST      32'h0000_0020
`define TIMS_CFG_RST       32'h0000_0010
`define TIMS_POS_RST       32'h0000_0000

// timing, in ms, the init entry onset count, and clock rate
`define TIMS_CLK_HZ        10000000
`define TIMS_SIMUL_MS      100
`define TIMS_ENTRY_MS      6000
`define TIMS_IDLE_MS       2000
`define TIMS_ENTRY_COUNT   9
`define TIMS_DEB_MS        10
`define TIMS_CYC_PER_MS    (`TIMS_CLK_HZ / 1000)

// ramp length, in ms
`define TIMS_RAMP_MS       50

`endif

// ---- logic/tims_sequencer.v ----
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tims_defs.vh"

module tims_sequencer #(
    parameter integer TICK_CYC = `TIMS_CYC_PER_MS,
    parameter integer DEB_MS   = `TIMS_DEB_MS,
    parameter integer SIMUL_MS = `TIMS_SIMUL_MS,
    parameter integer ENTRY_MS = `TIMS_ENTRY_MS,
    parameter integer IDLE_MS  = `TIMS_IDLE_MS,
    parameter integer RAMP_MS  = `TIMS_RAMP_MS
) (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        travel1_i,
    input  wire        travel2_i,
    input  wire        at_max1_i,
    input  wire        at_max2_i,
    input  wire        at_target_i,
    input  wire        home_switch_i,
    input  wire [3:0]  active_slaves_i,
    input  wire        addr_ok_i,
    input  wire        dev_fault_i,
    input  wire        last_in_chain_i,
    input  wire [3:0]  chain_pos_i,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    output reg         move_up_o,
    output reg         move_down_o,
    output reg  [7:0]  speed_o,
    output reg         sync_en_o,
    output reg         equalize_o,
    output reg         init_mode_o,
    output reg         init_run_o,
    output reg         set_reference_o,
    output reg  [3:0]  node_addr_o,
    output reg         term_en_o,
    output reg         nv_store_o,
    output reg         blocked_o
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_UP   = 4'b0010;
    localparam [3:0] ST_DOWN = 4'b0100;
    localparam [3:0] ST_INIT = 4'b1000;
    localparam [7:0] FULL_SPEED = 8'hff;
    localparam integer ENTRY_N = `TIMS_ENTRY_COUNT;

    function [15:0] ms_inc;
        input [15:0] v;
        begin
            ms_inc = (v == 16'hffff) ? v : v + 16'h0001;
        end
    endfunction

    reg [3:0]  st_q;
    reg [15:0] div_q;
    reg        tick_q;
    reg [1:0]  raw_q;
    reg [1:0]  deb_q;
    reg [15:0] deb_cnt_q [0:1];
    reg [1:0]  deb_prev_q;
    reg [15:0] since1_q;
    reg [15:0] since2_q;
    reg [3:0]  joint_cnt_q;
    reg [15:0] win_q;
    reg [15:0] idle_q;
    reg        homed_q;
    reg [15:0] ramp_q;
    reg [31:0] ctrl_q;
    reg [31:0] cfg_q;
    reg [31:0] pos_q;
    reg        man_term_q;
    reg [3:0]  man_addr_q;

    wire       both = deb_q[0] & deb_q[1];
    wire [1:0] rise = deb_q & ~deb_prev_q;
    wire       is_master = ctrl_q[`TIMS_CTRL_MASTER];
    wire       sync_mode = ctrl_q[`TIMS_CTRL_SYNC];
    // only a synchronous master supervises the chain
    wire       chain_bad = is_master & sync_mode & (
                   (active_slaves_i != cfg_q[3:0]) | ~addr_ok_i |
                   dev_fault_i);
    // a joint onset: second input rises within the window of the first
    wire joint_onset = (rise[0] & deb_q[1] &
                        (since2_q < SIMUL_MS[15:0])) |
                       (rise[1] & deb_q[0] &
                        (since1_q < SIMUL_MS[15:0])) |
                       (rise[0] & rise[1]);
    // ninth onset enters init from any travel state: a pattern that
    // leads with one input alone may already have started travel
    wire enter_init = (st_q != ST_INIT) & joint_onset &
                      (win_q < ENTRY_MS[15:0]) &
                      (joint_cnt_q == ENTRY_N[3:0] - 4'h1);
    wire acc = psel & penable;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // ms tick and debounce
    // a key must differ across DEB_MS tick pulses, the first possibly partial; chatter restarts it
    integer k;
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            div_q      <= 16'h0000;
            tick_q     <= 1'b0;
            raw_q      <= 2'b00;
            deb_q      <= 2'b00;
            deb_prev_q <= 2'b00;
            for (k = 0; k < 2; k = k + 1)
                deb_cnt_q[k] <= 16'h0000;
        end else begin
            tick_q <= (div_q == TICK_CYC[15:0] - 16'h0001);
            div_q  <= (div_q == TICK_CYC[15:0] - 16'h0001) ? 16'h0000
                      : div_q + 16'h0001;
            raw_q      <= {travel2_i, travel1_i};
            deb_prev_q <= deb_q;
            for (k = 0; k < 2; k = k + 1) begin
                if (raw_q[k] == deb_q[k])
                    deb_cnt_q[k] <= 16'h0000;
                else if (tick_q) begin
                    if (deb_cnt_q[k] >= DEB_MS[15:0] - 16'h0001) begin
                        deb_q[k]     <= raw_q[k];
                        deb_cnt_q[k] <= 16'h0000;
                    end else begin
                        deb_cnt_q[k] <= deb_cnt_q[k] + 16'h0001;
                    end
                end
            end
        end
    end

    // onset ages and pattern windows
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            since1_q    <= 16'hffff;
            since2_q    <= 16'hffff;
            joint_cnt_q <= 4'h0;
            win_q       <= 16'h0000;
            idle_q      <= 16'h0000;
        end else begin
            // ages saturate so a long-held key never looks recent
            since1_q <= rise[0] ? 16'h0000
                        : (tick_q ? ms_inc(since1_q) : since1_q);
            since2_q <= rise[1] ? 16'h0000
                        : (tick_q ? ms_inc(since2_q) : since2_q);
            if (st_q == ST_INIT) begin
                joint_cnt_q <= 4'h0;
                if (both)
                    idle_q <= 16'h0000;
                else if (tick_q)
                    idle_q <= ms_inc(idle_q);
            end else begin
                idle_q <= 16'h0000;
                if (joint_onset) begin
                    // an onset after the window lapsed opens a new one
                    if (joint_cnt_q == 4'h0 ||
                        win_q >= ENTRY_MS[15:0]) begin
                        win_q <= 16'h0000;
                        joint_cnt_q <= 4'h1;
                    end else begin
                        joint_cnt_q <= joint_cnt_q + 4'h1;
                    end
                end else if (joint_cnt_q != 4'h0 && tick_q) begin
                    win_q <= ms_inc(win_q);
                    if (win_q >= ENTRY_MS[15:0])
                        joint_cnt_q <= 4'h0;
                end
            end
        end
    end

    // travel and init sequencer
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_q            <= ST_IDLE;
            move_up_o       <= 1'b0;
            move_down_o     <= 1'b0;
            speed_o         <= 8'h00;
            ramp_q          <= 16'h0000;
            sync_en_o       <= 1'b0;
            equalize_o      <= 1'b0;
            init_mode_o     <= 1'b0;
            init_run_o      <= 1'b0;
            set_reference_o <= 1'b0;
            homed_q         <= 1'b0;
            node_addr_o     <= 4'h0;
            term_en_o       <= 1'b0;
            nv_store_o      <= 1'b0;
            blocked_o       <= 1'b0;
        end else begin
            set_reference_o <= 1'b0;
            nv_store_o      <= 1'b0;
            blocked_o       <= chain_bad;
            sync_en_o       <= sync_mode & (st_q != ST_INIT);
            // slaves may trim position while no travel is commanded
            equalize_o      <= sync_mode & ~is_master & ~dev_fault_i &
                               (st_q == ST_IDLE);
            if (ctrl_q[`TIMS_CTRL_TERM_WE])
                term_en_o <= man_term_q;
            if (ctrl_q[`TIMS_CTRL_ADDR_WE])
                node_addr_o <= man_addr_q;
            case (st_q)
            ST_IDLE: begin
                move_up_o   <= 1'b0;
                move_down_o <= 1'b0;
                // ramp off: speed falls one ramp step per tick, or to zero on the next tick with the ramp disabled
                if (speed_o != 8'h00 && tick_q)
                    speed_o <= ramp_step(speed_o);
                if (enter_init) begin
                    st_q        <= ST_INIT;
                    init_mode_o <= 1'b1;
                    homed_q     <= 1'b0;
                end else if (!chain_bad && deb_q == 2'b01 &&
                             !at_max1_i && !at_target_i) begin
                    st_q <= ST_UP;
                end else if (!chain_bad && deb_q == 2'b10 &&
                             !at_max2_i && !at_target_i) begin
                    st_q <= ST_DOWN;
                end
            end
            ST_UP, ST_DOWN: begin
                move_up_o   <= (st_q == ST_UP);
                move_down_o <= (st_q == ST_DOWN);
                speed_o     <= FULL_SPEED;
                // init entry wins over a stop in the same cycle
                if (enter_init) begin
                    st_q        <= ST_INIT;
                    init_mode_o <= 1'b1;
                    homed_q     <= 1'b0;
                    move_up_o   <= 1'b0;
                    move_down_o <= 1'b0;
                end else if (chain_bad || at_target_i ||
                    (st_q == ST_UP ? (at_max1_i || deb_q != 2'b01)
                                   : (at_max2_i || deb_q != 2'b10)))
                    st_q <= ST_IDLE;
            end
            ST_INIT: begin
                init_run_o  <= both & ~homed_q;
                move_down_o <= both & ~homed_q & ~home_switch_i;
                move_up_o   <= 1'b0;
                speed_o     <= (both & ~homed_q) ? FULL_SPEED : 8'h00;
                if (both) begin
                    node_addr_o <= is_master ? 4'h0 : chain_pos_i;
                    // terminate only chain ends; mid slaves go dark
                    term_en_o <= is_master | last_in_chain_i;
                end
                if (both && !homed_q && home_switch_i) begin
                    homed_q         <= 1'b1;
                    set_reference_o <= 1'b1;
                    nv_store_o      <= 1'b1;
                end
                // leaving init re-arms termination at both chain ends
                if (idle_q >= IDLE_MS[15:0]) begin
                    st_q        <= ST_IDLE;
                    init_mode_o <= 1'b0;
                    init_run_o  <= 1'b0;
                    move_down_o <= 1'b0;
                    term_en_o   <= is_master | last_in_chain_i;
                end
            end
            default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ramp: linear fall over RAMP_MS milliseconds
    function [7:0] ramp_step;
        input [7:0] s;
        reg   [7:0] d;
        begin
            d = (RAMP_MS > 255) ? 8'h01 : 8'hff / RAMP_MS[7:0];
            if (!ctrl_q[`TIMS_CTRL_RAMP_EN] || s <= d)
                ramp_step = 8'h00;
            else
                ramp_step = s - d;
        end
    endfunction

    // apb registers
    // zero wait states; the position word is a spare reading zero
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctrl_q     <= `TIMS_CTRL_RST;
            cfg_q      <= `TIMS_CFG_RST;
            pos_q      <= `TIMS_POS_RST;
            man_term_q <= 1'b0;
            man_addr_q <= 4'h0;
        end else if (acc && pwrite) begin
            case (paddr)
            `TIMS_CTRL_OFF:  ctrl_q <= pwdata;
            `TIMS_CFG_OFF:   cfg_q  <= pwdata;
            `TIMS_CHAIN_OFF: begin
                man_term_q <= pwdata[4];
                man_addr_q <= pwdata[3:0];
            end
            default: pos_q <= pos_q;
            endcase
        end
    end

    always @* begin
        case (paddr)
        `TIMS_CTRL_OFF:  prdata = ctrl_q;
        `TIMS_CFG_OFF:   prdata = cfg_q;
        `TIMS_POS_OFF:   prdata = pos_q;
        `TIMS_STAT_OFF:  prdata = {16'h0000, joint_cnt_q, st_q,
                                   2'b00, homed_q, blocked_o,
                                   term_en_o, init_run_o,
                                   init_mode_o, deb_q[1]};
        `TIMS_CHAIN_OFF: prdata = {27'h0000000, term_en_o, node_addr_o};
        default:         prdata = 32'h0000_0000;
        endcase
    end

endmodule

// ---- verif/tims_hand_switch.sv ----
`timescale 1ns/1ps
// far-side hand switch: key code appears on the lines one edge later
module tims_hand_switch (
    input  wire logic [1:0] keys_i,
    input  wire logic       clk_i,
    output logic            travel1_o = 1'h0,
    output logic            travel2_o = 1'h0
);
    // both keys together only in the init patterns the bench asks for
    always @(posedge clk_i) begin
        travel1_o <= keys_i[0];
        travel2_o <= keys_i[1];
    end
endmodule

// ---- verif/tims_seq_monitor.sv ----
`timescale 1ns/1ps
module tims_seq_monitor #(
    parameter integer TICK_CYC = 10,
    parameter integer DEB_MS   = 1,
    parameter integer IDLE_MS  = 20
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire travel1_i,
    input wire travel2_i,
    input wire at_max1_i,
    input wire at_target_i,
    input wire move_up_o,
    input wire move_down_o,
    input wire sync_en_o,
    input wire init_mode_o,
    input wire init_run_o,
    input wire set_reference_o,
    input wire blocked_o
);
    // slack: debounce counted in whole ticks plus register stages
    localparam integer DEB_LIM  = TICK_CYC * (DEB_MS + 2) + 4;
    localparam integer IDLE_LIM = TICK_CYC * (IDLE_MS + DEB_MS + 3) + 4;
    integer low1_q;
    integer apart_q;
    wire    both   = travel1_i && travel2_i;
    wire    moving = move_up_o || move_down_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    always @(posedge clk_i) begin
        low1_q  <= (!reset_n_i || travel1_i) ? 0 : low1_q + 1;
        apart_q <= (!reset_n_i || both) ? 0 : apart_q + 1;
    end
    property p_one_dir; !(move_up_o && move_down_o); endproperty
    a_one_dir: assert property (p_one_dir)
        else $error("up and down together");
    property p_end; move_up_o && at_max1_i |-> ##[1:4] !move_up_o; endproperty
    a_end: assert property (p_end)
        else $error("travel past end position");
    property p_target; moving && at_target_i && !init_run_o |-> ##[1:4] !moving;
    endproperty
    a_target: assert property (p_target)
        else $error("travel past target");
    property p_release; low1_q >= DEB_LIM |-> !move_up_o; endproperty
    a_release: assert property (p_release)
        else $error("still moving after release");
    property p_block; $rose(blocked_o) && !init_mode_o |-> ##[0:3] !moving;
    endproperty
    a_block: assert property (p_block)
        else $error("moving while blocked");
    property p_run; init_run_o |-> init_mode_o && !move_up_o && !sync_en_o;
    endproperty
    a_run: assert property (p_run)
        else $error("bad init run state");
    property p_held; apart_q >= DEB_LIM |-> !init_run_o; endproperty
    a_held: assert property (p_held)
        else $error("init run without both inputs");
    property p_idle; apart_q >= IDLE_LIM |-> !init_mode_o; endproperty
    a_idle: assert property (p_idle)
        else $error("init mode kept too long");
    property p_ref; set_reference_o |-> init_mode_o ##1 !set_reference_o;
    endproperty
    a_ref: assert property (p_ref)
        else $error("bad reference pulse");
    c_run: cover property ($rose(init_run_o));
    c_ref: cover property (set_reference_o);
    c_block: cover property ($rose(blocked_o));
endmodule

// ---- verif/test_two_input_mode_sequencer.sv ----
`timescale 1ns/1ps
`include "tims_defs.vh"
module test_two_input_mode_sequencer;
    localparam integer TICK = 10;
    localparam integer DEB  = TICK * 3 + 4;
    logic        clk_i = 1'h0, reset_n_i = 1'h0, psel = 1'h0;
    logic        penable = 1'h0, pwrite = 1'h0, addr_ok_i = 1'h1;
    logic        at_max1_i = 1'h0, at_max2_i = 1'h0, at_target_i = 1'h0;
    logic        home_switch_i = 1'h0, dev_fault_i = 1'h0;
    logic        last_in_chain_i = 1'h1, travel1_i, travel2_i;
    logic [1:0]  keys = 2'h0;
    logic [3:0]  active_slaves_i = 4'h0, chain_pos_i = 4'h0, node_addr_o;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'haad7;
    logic [7:0]  speed_o;
    logic        pready, pslverr, move_up_o, move_down_o, sync_en_o;
    logic        equalize_o, init_mode_o, init_run_o, set_reference_o;
    logic        term_en_o, nv_store_o, blocked_o;
    integer      miscompares = 0, checks = 0, n, k;
    always #50 clk_i = ~clk_i;
    tims_hand_switch u_tims_hand_switch (.keys_i(keys), .clk_i(clk_i),
        .travel1_o(travel1_i), .travel2_o(travel2_i));
    tims_sequencer #(.TICK_CYC(TICK), .DEB_MS(1), .SIMUL_MS(5),
        .ENTRY_MS(200), .IDLE_MS(20), .RAMP_MS(5)) u_tims_sequencer (.*);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic timeout_if(input logic bad);
        if (bad) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask
    task automatic tick(input integer c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (pready !== 1'h1 && n < 50);
        timeout_if(pready !== 1'h1);
        rd = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    initial begin
        tick(6);
        reset_n_i <= 1'h1;
        apb(1'h1, `TIMS_POS_OFF, rnd());
        apb(1'h1, 12'h020, rnd());
        for (k = 0; k < 4; k++) begin
            apb(1'h0, k == 3 ? 12'h020 : 12'(4 * k), 32'h0);
            check(rd, k == 0 ? `TIMS_CTRL_RST : k == 1 ? `TIMS_CFG_RST : 0);
        end
        apb(1'h1, `TIMS_CTRL_OFF, 32'h38);
        r = rnd();
        apb(1'h1, `TIMS_CHAIN_OFF, {27'h0, 1'h0, r[3:0]});
        tick(3);
        check({node_addr_o, term_en_o}, {r[3:0], 1'h0});
        apb(1'h1, `TIMS_CTRL_OFF, 32'h23);
        apb(1'h1, `TIMS_CFG_OFF, {28'h0, r[3:0]});
        active_slaves_i <= r[3:0];
        $display("test registers done");
        for (k = 0; k < 2; k++) begin
            keys <= 2'(k + 1);
            tick(DEB);
            check({move_up_o, move_down_o}, k ? 2'h1 : 2'h2);
            check({sync_en_o, equalize_o}, 2'h2);
            at_max1_i   <= 1'(k == 0);
            at_target_i <= 1'(k == 1);
            tick(6);
            check({move_up_o, move_down_o}, 2'h0);
            keys        <= 2'h0;
            tick(DEB);
            at_max1_i   <= 1'h0;
            at_target_i <= 1'h0;
        end
        keys <= 2'h1;
        tick(DEB + 10 * TICK);
        keys <= 2'h0;
        for (n = 0; n < 200 && move_up_o !== 1'h0; n++) @(posedge clk_i);
        timeout_if(n >= 200);
        check(n < DEB, 1'h1);
        check(speed_o != 8'h0, 1'h1);
        tick(7 * TICK);
        check(speed_o, 8'h0);
        $display("test travel done");
        for (k = 0; k < 3; k++) begin
            addr_ok_i       <= 1'(k != 0);
            dev_fault_i     <= 1'(k == 1);
            active_slaves_i <= r[3:0] + 4'(k == 2);
            keys            <= 2'h1;
            tick(DEB);
            check({blocked_o, move_up_o}, 2'h2);
            keys            <= 2'h0;
            addr_ok_i       <= 1'h1;
            dev_fault_i     <= 1'h0;
            active_slaves_i <= r[3:0];
            tick(DEB);
        end
        $display("test blocking done");
        apb(1'h1, `TIMS_CTRL_OFF, 32'h22);
        chain_pos_i <= 4'(rnd() % 15 + 1);
        tick(2);
        check(equalize_o, 1'h1);
        for (k = 0; k < 9; k++) begin
            check(init_mode_o, 1'h0);
            r = rnd();
            keys <= 2'h1;
            tick(r % 4 * TICK + 1);
            keys <= 2'h3;
            tick(3 * TICK);
            keys <= 2'h0;
            tick(3 * TICK);
        end
        check(init_mode_o, 1'h1);
        for (k = 0; k < 2; k++) begin
            keys <= 2'h3;
            tick(DEB);
            check({init_run_o, move_down_o}, 2'h3);
            keys <= 2'h0;
            tick(DEB);
            check(init_run_o, 1'h0);
        end
        keys <= 2'h3;
        tick(DEB);
        home_switch_i <= 1'h1;
        for (n = 0; n < 300 && set_reference_o !== 1'h1; n++)
            @(posedge clk_i);
        timeout_if(n >= 300);
        check(nv_store_o, 1'h1);
        tick(3);
        check({node_addr_o, term_en_o}, {chain_pos_i, 1'h1});
        check(move_down_o, 1'h0);
        keys          <= 2'h0;
        home_switch_i <= 1'h0;
        tick(24 * TICK + 4);
        check(init_mode_o, 1'h0);
        check(term_en_o, 1'h1);
        $display("test init done");
        report_and_stop();
    end
endmodule
bind tims_sequencer tims_seq_monitor #(.TICK_CYC(TICK_CYC),
    .DEB_MS(DEB_MS), .IDLE_MS(IDLE_MS)) u_tims_seq_monitor (.*);
